//--- design/crs_pkg.sv
/*
  Constants for the core register set and status block: field positions,
  reset values, selector and size codes.
  Assumes one core clock and an active-low asynchronous reset.
*/
package crs_pkg;
  localparam logic [1:0] SEL_PSR         = 2'h0;
  localparam logic [1:0] SEL_EPSR        = 2'h1;
  localparam logic [1:0] SEL_BREAK       = 2'h2;
  localparam int         PSR_BR          = 0;
  localparam int         PSR_BW          = 1;
  localparam int         PSR_CC          = 2;
  localparam int         PSR_LCC         = 3;
  localparam int         PSR_IM          = 4;
  localparam int         PSR_PIM         = 5;
  localparam int         PSR_U           = 6;
  localparam int         PSR_PU          = 7;
  localparam int         PSR_TRAP_LSB    = 8;
  localparam int         TRAP_W          = 5;
  localparam int         PSR_DS          = 13;
  localparam int         PSR_DIM         = 14;
  localparam int         PSR_KNF         = 15;
  localparam int         PSR_SC_LSB      = 17;
  localparam int         SC_W            = 5;
  localparam int         PSR_PS_LSB      = 22;
  localparam int         PSR_PM_LSB      = 24;
  localparam int         PM_W            = 8;
  localparam logic [31:0] PSR_USER_WMASK = 32'hfffe000c;
  localparam logic [31:0] PSR_RESET      = 32'h00000000;
  localparam logic [31:0] BREAK_RESET    = 32'h00000000;
  localparam int         EPSR_TYPE_LSB   = 0;
  localparam int         EPSR_STEP_LSB   = 8;
  localparam int         EPSR_IL         = 16;
  localparam int         EPSR_WP         = 17;
  localparam logic [1:0] SIZE_32         = 2'h0;
  localparam logic [1:0] SIZE_64         = 2'h1;
  localparam logic [1:0] SIZE_128        = 2'h2;
  localparam logic [1:0] PS_8            = 2'h0;
  localparam logic [1:0] PS_16           = 2'h1;
  localparam logic [1:0] PS_32           = 2'h2;
endpackage

//--- design/crs_rf_if.sv
/*
  Carrier between the status block and its register files.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface crs_rf_if;
  logic [4:0]   int_ra;
  logic [4:0]   int_rb;
  logic         int_we;
  logic [4:0]   int_wa;
  logic [31:0]  int_wd;
  logic [31:0]  int_rd_a;
  logic [31:0]  int_rd_b;
  logic [4:0]   flt_ra;
  logic [1:0]   flt_rsize;
  logic         flt_we;
  logic [4:0]   flt_wa;
  logic [1:0]   flt_wsize;
  logic [127:0] flt_wd;
  logic [127:0] flt_rd;
  modport rf   (input int_ra, int_rb, int_we, int_wa, int_wd, flt_ra, flt_rsize, flt_we, flt_wa, flt_wsize,
                flt_wd, output int_rd_a, int_rd_b, flt_rd);
  modport core (output int_ra, int_rb, int_we, int_wa, int_wd, flt_ra, flt_rsize, flt_we, flt_wa, flt_wsize,
                flt_wd, input int_rd_a, int_rd_b, flt_rd);
endinterface // crs_rf_if

//--- design/crs_regfile.sv
/*
  Integer and floating-point register files with registered read data.
  Assumes requests come from logic on the same clock.
*/
`timescale 1ns/10ps
module crs_regfile
(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  crs_rf_if.rf      rf
);
  typedef struct packed
  {
    logic [31:0][31:0] ifile;
    logic [31:0][31:0] ffile;
    logic [31:0]       ird_a;
    logic [31:0]       ird_b;
    logic [127:0]      frd;
  } crs_rf_state_t;

  crs_rf_state_t s_ff;
  crs_rf_state_t nxt_s;

  function automatic logic [4:0] align(input logic [4:0] a, input logic [1:0] sz);
    logic [4:0] m;
    m = (sz == crs_pkg::SIZE_128) ? 5'h1c : (sz == crs_pkg::SIZE_64) ? 5'h1e : 5'h1f;
    return a & m;
  endfunction

  function automatic int words(input logic [1:0] sz);
    return (sz == crs_pkg::SIZE_128) ? 4 : (sz == crs_pkg::SIZE_64) ? 2 : 1;
  endfunction

  always_comb
  begin
    logic [4:0] idx;
    idx   = 5'h00;
    nxt_s = s_ff;
    if (rf.int_we && (rf.int_wa != 5'h00))
    begin
      nxt_s.ifile[rf.int_wa] = rf.int_wd;
    end
    nxt_s.ird_a = (rf.int_ra == 5'h00) ? 32'h00000000 : s_ff.ifile[rf.int_ra];
    nxt_s.ird_b = (rf.int_rb == 5'h00) ? 32'h00000000 : s_ff.ifile[rf.int_rb];
    for (int k = 0; k < 4; k++)
    begin
      idx = align(rf.flt_wa, rf.flt_wsize) + 5'(k);
      if (rf.flt_we && (k < words(rf.flt_wsize)) && (idx > 5'h01))
      begin
        nxt_s.ffile[idx] = rf.flt_wd[k*32 +: 32];
      end
      idx = align(rf.flt_ra, rf.flt_rsize) + 5'(k);
      if ((k < words(rf.flt_rsize)) && (idx > 5'h01))
      begin
        nxt_s.frd[k*32 +: 32] = s_ff.ffile[idx];
      end
      else
      begin
        nxt_s.frd[k*32 +: 32] = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign rf.int_rd_a = s_ff.ird_a;
  assign rf.int_rd_b = s_ff.ird_b;
  assign rf.flt_rd   = s_ff.frd;
endmodule // crs_regfile

//--- design/crs_core_status.sv
/*
  Core register set and status block: status and extended status registers,
  breakpoint register, trap bookkeeping, mode switching, pixel store masking,
  and the integer and floating-point register files.
  Assumes all inputs come from pipeline logic on SYS_CLK_IN, so none is synchronised.
*/
`timescale 1ns/10ps
module crs_core_status
#(
  parameter logic [7:0] PROC_TYPE = 8'h5a,
  parameter logic [4:0] STEPPING  = 5'h03
)
(
  input  wire logic         SYS_CLK_IN,
  input  wire logic         ARST_N_IN,
  input  wire logic [4:0]   INT_RA_IN,
  input  wire logic [4:0]   INT_RB_IN,
  input  wire logic         INT_WE_IN,
  input  wire logic [4:0]   INT_WA_IN,
  input  wire logic [31:0]  INT_WD_IN,
  output logic      [31:0]  INT_RD_A_OUT,
  output logic      [31:0]  INT_RD_B_OUT,
  input  wire logic [4:0]   FLT_RA_IN,
  input  wire logic [1:0]   FLT_RSIZE_IN,
  input  wire logic         FLT_WE_IN,
  input  wire logic [4:0]   FLT_WA_IN,
  input  wire logic [1:0]   FLT_WSIZE_IN,
  input  wire logic [127:0] FLT_WD_IN,
  output logic      [127:0] FLT_RD_OUT,
  input  wire logic         CTRL_RE_IN,
  input  wire logic         CTRL_WE_IN,
  input  wire logic [1:0]   CTRL_SEL_IN,
  input  wire logic [31:0]  CTRL_WD_IN,
  output logic      [31:0]  CTRL_RD_OUT,
  output logic              CTRL_FAULT_OUT,
  input  wire logic         OPND_VALID_IN,
  input  wire logic         OPND_WRITE_IN,
  input  wire logic [2:0]   OPND_SIZE_IN,
  input  wire logic [31:0]  OPND_ADDR_IN,
  input  wire logic         PAGE_WRITE_OK_IN,
  output logic              DATA_TRAP_OUT,
  output logic              WRITE_PROT_TRAP_OUT,
  input  wire logic         EXT_INT_IN,
  input  wire logic         BUS_ERR_INT_IN,
  output logic              INT_TAKEN_OUT,
  input  wire logic         TRAP_IN,
  input  wire logic [4:0]   TRAP_CAUSE_IN,
  input  wire logic         DUAL_ACTIVE_IN,
  input  wire logic         SWITCH_NEXT_IN,
  input  wire logic         LOCKED_IN,
  input  wire logic         RETURN_IN,
  input  wire logic         INSTR_RETIRE_IN,
  output logic              MODE_SWITCH_OUT,
  output logic              MODE_DUAL_OUT,
  output logic              USER_MODE_OUT,
  output logic              FLOAT_KILL_OUT,
  input  wire logic         BYPASS_DONE_IN,
  input  wire logic         RSHIFT_IN,
  input  wire logic [4:0]   RSHIFT_AMT_IN,
  output logic      [4:0]   SHIFT_COUNT_OUT,
  input  wire logic         CC_WE_IN,
  input  wire logic         CC_IN,
  output logic              CONDITION_OUT,
  input  wire logic         LOOP_WE_IN,
  input  wire logic         LOOP_CC_IN,
  output logic              LOOP_TAKEN_OUT,
  input  wire logic         PST_IN,
  input  wire logic [63:0]  PST_DATA_IN,
  output logic              PST_VALID_OUT,
  output logic      [7:0]   PST_BYTE_EN_OUT,
  output logic      [63:0]  PST_DATA_OUT
);
  typedef struct packed
  {
    logic [31:0] psr;
    logic [31:0] brk;
    logic        il;
    logic        wp;
    logic [31:0] crd;
    logic        fault;
    logic        dtrap;
    logic        wtrap;
    logic        int_taken;
    logic        sw_pend;
    logic        sw_pulse;
    logic        sw_dual;
    logic        dual;
    logic        loop_taken;
    logic        pst_valid;
    logic [7:0]  pst_be;
    logic [63:0] pst_data;
  } crs_state_t;

  crs_state_t s_ff;
  crs_state_t nxt_s;
  crs_rf_if   rf_bus ();

  function automatic logic [31:0] size_mask(input logic [2:0] sz);
    logic [31:0] m;
    m = 32'hffffffff;
    for (int i = 0; i < 5; i++)
    begin
      if (32'(i) < 32'(sz))
      begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction

  function automatic logic [7:0] pixel_bytes(input logic [1:0] ps, input logic [7:0] pm);
    logic [7:0] be;
    be = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      case (ps)
        crs_pkg::PS_8:  be[i] = pm[i];
        crs_pkg::PS_16: be[i] = pm[i / 2];
        crs_pkg::PS_32: be[i] = pm[i / 4];
        default:        be[i] = 1'b0;
      endcase
    end
    return be;
  endfunction

  function automatic logic [31:0] epsr_value(input logic il, input logic wp);
    logic [31:0] v;
    v = 32'h00000000;
    v[crs_pkg::EPSR_TYPE_LSB +: 8] = PROC_TYPE;
    v[crs_pkg::EPSR_STEP_LSB +: 5] = STEPPING;
    v[crs_pkg::EPSR_IL]            = il;
    v[crs_pkg::EPSR_WP]            = wp;
    return v;
  endfunction

  always_comb
  begin
    logic       user;
    logic       bp_hit;
    logic       int_hit;
    logic       wp_hit;
    logic       trap_now;
    logic [4:0] causes;
    logic [4:0] flags;
    user     = s_ff.psr[crs_pkg::PSR_U];
    flags    = s_ff.psr[crs_pkg::PSR_TRAP_LSB +: crs_pkg::TRAP_W];
    nxt_s    = s_ff;
    bp_hit   = OPND_VALID_IN && ((OPND_ADDR_IN & size_mask(OPND_SIZE_IN)) ==
               (s_ff.brk & size_mask(OPND_SIZE_IN))) &&
               ((!OPND_WRITE_IN && s_ff.psr[crs_pkg::PSR_BR]) ||
                (OPND_WRITE_IN && s_ff.psr[crs_pkg::PSR_BW]));
    wp_hit   = OPND_VALID_IN && OPND_WRITE_IN && !PAGE_WRITE_OK_IN && (user || s_ff.wp);
    int_hit  = (EXT_INT_IN && s_ff.psr[crs_pkg::PSR_IM]) || BUS_ERR_INT_IN;
    causes   = TRAP_CAUSE_IN & {5{TRAP_IN}};
    causes[1] = causes[1] | int_hit;
    causes[3] = causes[3] | bp_hit;
    trap_now = TRAP_IN || bp_hit || int_hit || wp_hit;
    nxt_s.fault      = 1'b0;
    nxt_s.sw_pulse   = 1'b0;
    nxt_s.loop_taken = 1'b0;
    nxt_s.dtrap      = bp_hit;
    nxt_s.wtrap      = wp_hit;
    nxt_s.int_taken  = int_hit;
    nxt_s.pst_valid  = PST_IN;
    if (PST_IN)
    begin
      nxt_s.pst_be   = pixel_bytes(s_ff.psr[crs_pkg::PSR_PS_LSB +: 2],
                                   s_ff.psr[crs_pkg::PSR_PM_LSB +: crs_pkg::PM_W]);
      nxt_s.pst_data = PST_DATA_IN;
    end
    if (CTRL_RE_IN)
    begin
      case (CTRL_SEL_IN)
        crs_pkg::SEL_PSR:   nxt_s.crd = s_ff.psr;
        crs_pkg::SEL_EPSR:  nxt_s.crd = epsr_value(s_ff.il, s_ff.wp);
        crs_pkg::SEL_BREAK: nxt_s.crd = s_ff.brk;
        default:            nxt_s.crd = 32'h00000000;
      endcase
    end
    if (CTRL_WE_IN)
    begin
      case (CTRL_SEL_IN)
        crs_pkg::SEL_PSR:
        begin
          if (user)
          begin
            nxt_s.psr = (s_ff.psr & ~crs_pkg::PSR_USER_WMASK) |
                        (CTRL_WD_IN & crs_pkg::PSR_USER_WMASK);
          end
          else
          begin
            nxt_s.psr = CTRL_WD_IN;
          end
        end
        crs_pkg::SEL_EPSR:
        begin
          if (user)
          begin
            nxt_s.fault = 1'b1;
          end
          else
          begin
            nxt_s.il = CTRL_WD_IN[crs_pkg::EPSR_IL];
            nxt_s.wp = CTRL_WD_IN[crs_pkg::EPSR_WP];
          end
        end
        crs_pkg::SEL_BREAK:
        begin
          if (user)
          begin
            nxt_s.fault = 1'b1;
          end
          else
          begin
            nxt_s.brk = CTRL_WD_IN;
          end
        end
        default: nxt_s.fault = 1'b1;
      endcase
    end
    if (CC_WE_IN)
    begin
      nxt_s.psr[crs_pkg::PSR_CC] = CC_IN;
    end
    if (LOOP_WE_IN)
    begin
      nxt_s.loop_taken             = s_ff.psr[crs_pkg::PSR_LCC];
      nxt_s.psr[crs_pkg::PSR_LCC]  = LOOP_CC_IN;
    end
    if (RSHIFT_IN)
    begin
      nxt_s.psr[crs_pkg::PSR_SC_LSB +: crs_pkg::SC_W] = RSHIFT_AMT_IN;
    end
    if (BYPASS_DONE_IN && !trap_now)
    begin
      nxt_s.psr[crs_pkg::PSR_KNF] = 1'b0;
    end
    if (trap_now)
    begin
      nxt_s.psr[crs_pkg::PSR_PIM] = s_ff.psr[crs_pkg::PSR_IM];
      nxt_s.psr[crs_pkg::PSR_PU]  = user;
      nxt_s.psr[crs_pkg::PSR_IM]  = 1'b0;
      nxt_s.psr[crs_pkg::PSR_U]   = 1'b0;
      nxt_s.psr[crs_pkg::PSR_TRAP_LSB +: crs_pkg::TRAP_W] =
        nxt_s.psr[crs_pkg::PSR_TRAP_LSB +: crs_pkg::TRAP_W] | causes;
      nxt_s.psr[crs_pkg::PSR_DIM] = DUAL_ACTIVE_IN;
      nxt_s.psr[crs_pkg::PSR_DS]  = SWITCH_NEXT_IN;
      nxt_s.sw_pend               = 1'b0;
      nxt_s.dual                  = 1'b0;
      if (LOCKED_IN)
      begin
        nxt_s.il = 1'b1;
      end
    end
    else if (RETURN_IN)
    begin
      if (flags != 5'h00)
      begin
        nxt_s.psr[crs_pkg::PSR_IM] = s_ff.psr[crs_pkg::PSR_PIM];
        nxt_s.psr[crs_pkg::PSR_U]  = s_ff.psr[crs_pkg::PSR_PU];
      end
      nxt_s.dual    = s_ff.psr[crs_pkg::PSR_DIM];
      nxt_s.sw_pend = s_ff.psr[crs_pkg::PSR_DS];
      nxt_s.sw_dual = !s_ff.psr[crs_pkg::PSR_DIM];
    end
    else if (s_ff.sw_pend && INSTR_RETIRE_IN)
    begin
      nxt_s.sw_pend  = 1'b0;
      nxt_s.sw_pulse = 1'b1;
      nxt_s.dual     = s_ff.sw_dual;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      s_ff     <= '0;
      s_ff.psr <= crs_pkg::PSR_RESET;
      s_ff.brk <= crs_pkg::BREAK_RESET;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign rf_bus.int_ra    = INT_RA_IN;
  assign rf_bus.int_rb    = INT_RB_IN;
  assign rf_bus.int_we    = INT_WE_IN;
  assign rf_bus.int_wa    = INT_WA_IN;
  assign rf_bus.int_wd    = INT_WD_IN;
  assign rf_bus.flt_ra    = FLT_RA_IN;
  assign rf_bus.flt_rsize = FLT_RSIZE_IN;
  assign rf_bus.flt_we    = FLT_WE_IN;
  assign rf_bus.flt_wa    = FLT_WA_IN;
  assign rf_bus.flt_wsize = FLT_WSIZE_IN;
  assign rf_bus.flt_wd    = FLT_WD_IN;

  crs_regfile u_regfile
  (
    .clk_in    (SYS_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .rf        (rf_bus.rf)
  );

  assign INT_RD_A_OUT        = rf_bus.int_rd_a;
  assign INT_RD_B_OUT        = rf_bus.int_rd_b;
  assign FLT_RD_OUT          = rf_bus.flt_rd;
  assign CTRL_RD_OUT         = s_ff.crd;
  assign CTRL_FAULT_OUT      = s_ff.fault;
  assign DATA_TRAP_OUT       = s_ff.dtrap;
  assign WRITE_PROT_TRAP_OUT = s_ff.wtrap;
  assign INT_TAKEN_OUT       = s_ff.int_taken;
  assign MODE_SWITCH_OUT     = s_ff.sw_pulse;
  assign MODE_DUAL_OUT       = s_ff.dual;
  assign USER_MODE_OUT       = s_ff.psr[crs_pkg::PSR_U];
  assign FLOAT_KILL_OUT      = s_ff.psr[crs_pkg::PSR_KNF];
  assign SHIFT_COUNT_OUT     = s_ff.psr[crs_pkg::PSR_SC_LSB +: crs_pkg::SC_W];
  assign CONDITION_OUT       = s_ff.psr[crs_pkg::PSR_CC];
  assign LOOP_TAKEN_OUT      = s_ff.loop_taken;
  assign PST_VALID_OUT       = s_ff.pst_valid;
  assign PST_BYTE_EN_OUT     = s_ff.pst_be;
  assign PST_DATA_OUT        = s_ff.pst_data;
endmodule // crs_core_status

//--- tb/crs_core_status_chk.sv
/*
  Port-level timing checks for the core register set and status block.
  Assumes it is bound to crs_core_status, one clock, async active-low reset.
*/
`timescale 1ns/10ps
module crs_core_status_chk
(
  input wire logic        SYS_CLK_IN,
  input wire logic        ARST_N_IN,
  input wire logic [4:0]  INT_RA_IN,
  input wire logic [31:0] INT_RD_A_OUT,
  input wire logic        CTRL_WE_IN,
  input wire logic        OPND_VALID_IN,
  input wire logic        OPND_WRITE_IN,
  input wire logic        PAGE_WRITE_OK_IN,
  input wire logic        WRITE_PROT_TRAP_OUT,
  input wire logic        USER_MODE_OUT,
  input wire logic        BUS_ERR_INT_IN,
  input wire logic        INT_TAKEN_OUT,
  input wire logic        TRAP_IN,
  input wire logic        MODE_DUAL_OUT,
  input wire logic        RSHIFT_IN,
  input wire logic [4:0]  RSHIFT_AMT_IN,
  input wire logic [4:0]  SHIFT_COUNT_OUT,
  input wire logic        PST_IN,
  input wire logic [63:0] PST_DATA_IN,
  input wire logic        PST_VALID_OUT,
  input wire logic [63:0] PST_DATA_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  property p_int_zero; INT_RA_IN == 5'h0 |=> INT_RD_A_OUT == 32'h0; endproperty
  a_int_zero: assert property (p_int_zero) else $error("integer entry zero read nonzero");
  property p_wp_user; OPND_VALID_IN && OPND_WRITE_IN && !PAGE_WRITE_OK_IN && USER_MODE_OUT |=> WRITE_PROT_TRAP_OUT;
  endproperty
  a_wp_user: assert property (p_wp_user) else $error("user write to protected page not trapped");
  property p_wp_none; !(OPND_VALID_IN && OPND_WRITE_IN && !PAGE_WRITE_OK_IN) |=> !WRITE_PROT_TRAP_OUT; endproperty
  a_wp_none: assert property (p_wp_none) else $error("write protect trap without cause");
  property p_bus_int; BUS_ERR_INT_IN |=> INT_TAKEN_OUT; endproperty
  a_bus_int: assert property (p_bus_int) else $error("bus error interrupt not taken");
  property p_trap_user; TRAP_IN && !CTRL_WE_IN |=> !USER_MODE_OUT; endproperty
  a_trap_user: assert property (p_trap_user) else $error("user bit kept over trap");
  property p_trap_dual; TRAP_IN |=> !MODE_DUAL_OUT; endproperty
  a_trap_dual: assert property (p_trap_dual) else $error("dual mode kept over trap");
  property p_shift; RSHIFT_IN && !CTRL_WE_IN |=> SHIFT_COUNT_OUT == $past(RSHIFT_AMT_IN); endproperty
  a_shift: assert property (p_shift) else $error("shift count not recorded");
  property p_pst; PST_IN |=> PST_VALID_OUT && PST_DATA_OUT == $past(PST_DATA_IN); endproperty
  a_pst: assert property (p_pst) else $error("pixel store output wrong");
  c_trap: cover property (TRAP_IN ##1 !USER_MODE_OUT);
  c_pst: cover property (PST_IN ##1 PST_VALID_OUT);
  c_bus: cover property (BUS_ERR_INT_IN ##1 INT_TAKEN_OUT);
endmodule // crs_core_status_chk

//--- tb/tb.sv
/*
  Self-checking bench for crs_core_status, random stimulus with corner cases.
  Assumes the design package is compiled first; the checker is bound below.
*/
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] PTYPE = 8'h3c; // Arbitrary value
  localparam logic [4:0] PSTEP = 5'h11; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic i_we, f_we, c_re, c_we, o_v, o_w, o_ok, ext, berr, trap, dual, swn, lock, ret, rtr, byp, rsh, ccwe, cc, lwe, loop_condition_flag;
  logic pst, c_flt, dtrap, wpt, itk, msw, mdual, umode, fkill, cond, ltk, pval;
  logic [4:0] i_ra, i_rb, i_wa, f_ra, f_wa, tcause, ramt, scnt;
  logic [1:0] f_rs, f_ws, c_sel;
  logic [2:0] o_sz;
  logic [31:0] i_wd, c_wd, o_a, rda, rdb, c_rd;
  logic [127:0] f_wd, f_rd;
  logic [63:0] pdin, pdout;
  logic [7:0] pbe;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  crs_core_status #(.PROC_TYPE(PTYPE), .STEPPING(PSTEP)) uut (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n),
    .INT_RA_IN(i_ra), .INT_RB_IN(i_rb), .INT_WE_IN(i_we), .INT_WA_IN(i_wa), .INT_WD_IN(i_wd), .INT_RD_A_OUT(rda),
    .INT_RD_B_OUT(rdb), .FLT_RA_IN(f_ra), .FLT_RSIZE_IN(f_rs), .FLT_WE_IN(f_we), .FLT_WA_IN(f_wa),
    .FLT_WSIZE_IN(f_ws), .FLT_WD_IN(f_wd), .FLT_RD_OUT(f_rd), .CTRL_RE_IN(c_re), .CTRL_WE_IN(c_we),
    .CTRL_SEL_IN(c_sel), .CTRL_WD_IN(c_wd), .CTRL_RD_OUT(c_rd), .CTRL_FAULT_OUT(c_flt), .OPND_VALID_IN(o_v),
    .OPND_WRITE_IN(o_w), .OPND_SIZE_IN(o_sz), .OPND_ADDR_IN(o_a), .PAGE_WRITE_OK_IN(o_ok), .DATA_TRAP_OUT(dtrap),
    .WRITE_PROT_TRAP_OUT(wpt), .EXT_INT_IN(ext), .BUS_ERR_INT_IN(berr), .INT_TAKEN_OUT(itk), .TRAP_IN(trap),
    .TRAP_CAUSE_IN(tcause), .DUAL_ACTIVE_IN(dual), .SWITCH_NEXT_IN(swn), .LOCKED_IN(lock), .RETURN_IN(ret),
    .INSTR_RETIRE_IN(rtr), .MODE_SWITCH_OUT(msw), .MODE_DUAL_OUT(mdual), .USER_MODE_OUT(umode),
    .FLOAT_KILL_OUT(fkill), .BYPASS_DONE_IN(byp), .RSHIFT_IN(rsh), .RSHIFT_AMT_IN(ramt), .SHIFT_COUNT_OUT(scnt),
    .CC_WE_IN(ccwe), .CC_IN(cc), .CONDITION_OUT(cond), .LOOP_WE_IN(lwe), .LOOP_CC_IN(loop_condition_flag), .LOOP_TAKEN_OUT(ltk),
    .PST_IN(pst), .PST_DATA_IN(pdin), .PST_VALID_OUT(pval), .PST_BYTE_EN_OUT(pbe), .PST_DATA_OUT(pdout));
  always #20 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  function automatic logic [7:0] be_exp(input logic [1:0] ps, input logic [7:0] pm);
    logic [7:0] be;
    for (int i = 0; i < 8; i++)
      be[i] = (ps == 2'h0) ? pm[i] : (ps == 2'h1) ? pm[i/2] : (ps == 2'h2) ? pm[i/4] : 1'b0;
    return be;
  endfunction
  task automatic cw(input logic [1:0] s, input logic [31:0] d, input logic f);
    @(posedge clk);
    c_we <= 1'b1;
    c_sel <= s;
    c_wd <= d;
    @(posedge clk);
    c_we <= 1'b0;
    #1;
    chk("ctrl fault", c_flt, f);
  endtask
  task automatic cr(input logic [1:0] s, input logic [31:0] e);
    @(posedge clk);
    c_re <= 1'b1;
    c_sel <= s;
    @(posedge clk);
    c_re <= 1'b0;
    #1;
    chk("ctrl read", c_rd, e);
  endtask
  task automatic op(input logic w, input logic [31:0] a, input logic ok, input logic edt, input logic ewp);
    @(posedge clk);
    o_v <= 1'b1;
    o_w <= w;
    o_a <= a;
    o_ok <= ok;
    o_sz <= 3'h2;
    @(posedge clk);
    o_v <= 1'b0;
    #1;
    chk("data trap", dtrap, edt);
    chk("write prot trap", wpt, ewp);
  endtask
  task automatic pulse_trap(input logic [4:0] c, input logic d, input logic b);
    @(posedge clk);
    trap <= 1'b1;
    tcause <= c;
    byp <= b;
    {dual, swn, lock} <= {3{d}};
    @(posedge clk);
    {trap, dual, swn, lock, byp} <= 5'h00;
    #1;
  endtask
  initial
  begin
    logic [31:0] d;
    logic [4:0] a;
    logic [127:0] fd, fe;
    logic [1:0] sz;
    logic prev;
    {i_we, f_we, c_re, c_we, o_v, o_w, o_ok, ext, berr, trap, dual, swn, lock, ret, rtr, byp, rsh, ccwe} = '0;
    {cc, lwe, loop_condition_flag, pst, i_ra, i_rb, i_wa, f_ra, f_wa, tcause, ramt, f_rs, f_ws, c_sel, o_sz} = '0;
    {i_wd, c_wd, o_a, f_wd, pdin} = '0;
    void'($urandom(53534));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cr(crs_pkg::SEL_PSR, crs_pkg::PSR_RESET);
    cr(crs_pkg::SEL_EPSR, {19'h0, PSTEP, PTYPE});
    tdone("reset");
    for (int i = 0; i < 8; i++)
    begin
      a = (i == 0) ? 5'h0 : 5'($urandom);
      d = $urandom;
      @(posedge clk);
      i_we <= 1'b1;
      i_wa <= a;
      i_wd <= d;
      @(posedge clk);
      i_we <= 1'b0;
      i_ra <= a;
      i_rb <= a;
      @(posedge clk);
      #1;
      chk("int a", rda, (a == 5'h0) ? 32'h0 : d);
      chk("int b", rdb, (a == 5'h0) ? 32'h0 : d);
    end
    tdone("integer file");
    for (int i = 0; i < 6; i++)
    begin
      sz = 2'(i % 3);
      a = (i < 3) ? 5'h0 : 5'($urandom);
      fd = {$urandom, $urandom, $urandom, $urandom};
      @(posedge clk);
      f_we <= 1'b1;
      f_wa <= a;
      f_ws <= sz;
      f_wd <= fd;
      a = a & ~((5'h1 << sz) - 5'h1);
      fe = '0;
      for (int k = 0; k < (1 << sz); k++)
        if (a + 5'(k) > 5'h1)
          fe[k*32 +: 32] = fd[k*32 +: 32];
      @(posedge clk);
      f_we <= 1'b0;
      f_ra <= a;
      f_rs <= sz;
      @(posedge clk);
      #1;
      chk("float wide", f_rd, fe);
      @(posedge clk);
      f_ra <= a + 5'((1 << sz) - 1);
      f_rs <= crs_pkg::SIZE_32;
      @(posedge clk);
      #1;
      chk("float top entry", f_rd, {96'h0, fe[((1 << sz) - 1)*32 +: 32]});
    end
    tdone("float file");
    d = $urandom;
    cw(crs_pkg::SEL_BREAK, d, 1'b0);
    cr(crs_pkg::SEL_BREAK, d);
    cw(2'h3, 32'h0, 1'b1);
    cr(2'h3, 32'h0);
    cw(crs_pkg::SEL_PSR, 32'h11, 1'b0);
    op(1'b1, d, 1'b1, 1'b0, 1'b0);
    op(1'b0, d ^ 32'h10, 1'b1, 1'b0, 1'b0);
    op(1'b0, d ^ 32'h3, 1'b1, 1'b1, 1'b0);
    cr(crs_pkg::SEL_PSR, 32'h821);
    tdone("breakpoint");
    for (int j = 0; j < 3; j++)
    begin
      if (j == 1)
        cw(crs_pkg::SEL_PSR, 32'h10, 1'b0);
      @(posedge clk);
      ext <= (j < 2);
      berr <= (j == 2);
      @(posedge clk);
      {ext, berr} <= 2'h0;
      #1;
      chk("int taken", itk, j > 0);
      if (j == 1)
        cr(crs_pkg::SEL_PSR, 32'h220);
    end
    tdone("interrupt");
    cw(crs_pkg::SEL_PSR, 32'h50, 1'b0);
    chk("user mode", umode, 1'b1);
    cw(crs_pkg::SEL_EPSR, 32'h0, 1'b1);
    a = 5'($urandom) | 5'h1;
    pulse_trap(a, 1'b1, 1'b0);
    chk("user after trap", umode, 1'b0);
    chk("dual after trap", mdual, 1'b0);
    cr(crs_pkg::SEL_PSR, 32'h60a0 | (32'(a) << 8));
    cr(crs_pkg::SEL_EPSR, {14'h0, 2'h1, 3'h0, PSTEP, PTYPE});
    cw(crs_pkg::SEL_EPSR, 32'h0, 1'b0);
    cr(crs_pkg::SEL_EPSR, {19'h0, PSTEP, PTYPE});
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    #1;
    chk("user after return", umode, 1'b1);
    chk("dual after return", mdual, 1'b1);
    @(posedge clk);
    rtr <= 1'b1;
    @(posedge clk);
    rtr <= 1'b0;
    #1;
    chk("mode switch", msw, 1'b1);
    chk("dual after switch", mdual, 1'b0);
    op(1'b1, 32'h0, 1'b0, 1'b0, 1'b1);
    op(1'b1, 32'h0, 1'b0, 1'b0, 1'b0);
    cw(crs_pkg::SEL_EPSR, 32'h20000, 1'b0);
    op(1'b1, 32'h0, 1'b0, 1'b0, 1'b1);
    op(1'b1, 32'h0, 1'b1, 1'b0, 1'b0);
    tdone("trap and protect");
    cw(crs_pkg::SEL_PSR, 32'h8000, 1'b0);
    chk("kill set", fkill, 1'b1);
    pulse_trap(5'h1, 1'b0, 1'b1);
    chk("kill kept", fkill, 1'b1);
    @(posedge clk);
    byp <= 1'b1;
    @(posedge clk);
    byp <= 1'b0;
    #1;
    chk("kill cleared", fkill, 1'b0);
    tdone("kill next float");
    prev = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      @(posedge clk);
      {rsh, ccwe, lwe} <= 3'h7;
      {loop_condition_flag, cc, ramt} <= d[6:0];
      @(posedge clk);
      {rsh, ccwe, lwe} <= 3'h0;
      #1;
      chk("shift count", scnt, d[4:0]);
      chk("condition", cond, d[5]);
      chk("loop taken", ltk, prev);
      prev = d[6];
    end
    tdone("shift and conditions");
    for (int p = 0; p < 4; p++)
    begin
      d = $urandom;
      cw(crs_pkg::SEL_PSR, {d[7:0], 2'(p), 22'h0}, 1'b0);
      fd[63:0] = {$urandom, $urandom};
      @(posedge clk);
      pst <= 1'b1;
      pdin <= fd[63:0];
      @(posedge clk);
      pst <= 1'b0;
      #1;
      chk("pixel valid", pval, 1'b1);
      chk("pixel enables", pbe, be_exp(2'(p), d[7:0]));
      chk("pixel data", pdout, fd[63:0]);
    end
    tdone("pixel store");
    finish_test();
  end
endmodule // tb
bind crs_core_status crs_core_status_chk chk (.SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .INT_RA_IN(INT_RA_IN),
  .INT_RD_A_OUT(INT_RD_A_OUT), .CTRL_WE_IN(CTRL_WE_IN), .OPND_VALID_IN(OPND_VALID_IN), .OPND_WRITE_IN(OPND_WRITE_IN),
  .PAGE_WRITE_OK_IN(PAGE_WRITE_OK_IN), .WRITE_PROT_TRAP_OUT(WRITE_PROT_TRAP_OUT), .USER_MODE_OUT(USER_MODE_OUT),
  .BUS_ERR_INT_IN(BUS_ERR_INT_IN), .INT_TAKEN_OUT(INT_TAKEN_OUT), .TRAP_IN(TRAP_IN), .MODE_DUAL_OUT(MODE_DUAL_OUT),
  .RSHIFT_IN(RSHIFT_IN), .RSHIFT_AMT_IN(RSHIFT_AMT_IN), .SHIFT_COUNT_OUT(SHIFT_COUNT_OUT), .PST_IN(PST_IN),
  .PST_DATA_IN(PST_DATA_IN), .PST_VALID_OUT(PST_VALID_OUT), .PST_DATA_OUT(PST_DATA_OUT));
